// [hw/mcu_irq_cfg.svh]
// Purpose: Constants of the interrupt controller: offsets, fields, resets, vectors
// Assumes: Register port with 4-bit address and 8-bit data
// Notes:   Included by the design file and the bench
`ifndef MCU_IRQ_CFG_SVH
`define MCU_IRQ_CFG_SVH

`define REG_ADDR_W          4
`define OFF_INTERRUPT_CTL   4'h0
`define OFF_PIN_CHANGE_SEL  4'h1
`define OFF_PERIPH_FLAGS    4'h2
`define OFF_PERIPH_ENABLES  4'h3
`define OFF_PIN_CONFIG      4'h4
`define OFF_ANALOG_SELECT   4'h5
`define OFF_STATUS          4'h6
`define OFF_POWER_CONTROL   4'h7

`define IC_GLOBAL_EN        7
`define IC_PERIPH_EN        6
`define IC_TIMER_EN         5
`define IC_EXT_EN           4
`define IC_CHANGE_EN        3
`define IC_TIMER_FLAG       2
`define IC_EXT_FLAG         1
`define IC_CHANGE_FLAG      0

`define PERIPH_IMPL_MASK    8'hef
`define PIN_MASK            6'h3f
`define EXT_PIN_INDEX       2
`define EDGE_SEL_BIT        0
`define ST_TO_BIT           4
`define ST_PD_BIT           3

`define IC_RESET            8'h00
`define PERIPH_RESET        8'h00
`define PIN_SEL_RESET       6'h00
`define ANALOG_RESET        6'h00
`define PIN_CFG_RESET       8'h00
`define STATUS_POR          8'h18
`define POWER_CONTROL_REG_POR            4'h4
`define POWER_CONTROL_REG_BOR            4'h6
`define PC_RESET            13'h0000
`define PC_VECTOR           13'h0004
`define TIMER_MAX           8'hff
`define TIMER_ZERO          8'h00

`endif

// [hw/mcu_irq_pkg.sv]
// Purpose: Types shared by the interrupt controller and its neighbours
// Assumes: Constants come from the cfg header
// Notes:   Program counter is 13 bits wide
package mcu_irq_pkg;
   typedef enum logic [1:0] {Q1, Q2, Q3, Q4} q_phase_t;
   typedef enum logic {RUNNING, ASLEEP} power_state_t;
   typedef enum logic {RST_EXT_PIN, RST_BROWN_OUT} reset_cause_t;

   typedef struct packed {
      logic         valid;
      reset_cause_t cause;
   } reset_req_t;

   typedef struct packed {
      logic        return_from_irq;
      logic        sleep_enter;
      logic        port_access;
      logic        wdt_timeout;
      logic [12:0] pc;
   } core_req_t;

   typedef struct packed {
      logic        pc_load;
      logic [12:0] pc_addr;
      logic        push;
      logic [12:0] push_addr;
   } core_ctl_t;
endpackage

// [hw/mcu_interrupt_controller.sv]
// Purpose: Interrupt flags, enables, vectoring, sleep wake-up and reset values
// Assumes: One clock, four Q phases per instruction cycle
// Notes:   i_nrst is power-on; pin and brown-out resets arrive as a request
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "mcu_irq_cfg.svh"

module mcu_interrupt_controller (
   input  wire logic                    i_core_clk,
   input  wire logic                    i_nrst,
   input  wire logic [3:0]              i_reg_addr,
   input  wire logic [7:0]              i_reg_wdata,
   input  wire logic                    i_reg_wr,
   input  wire logic                    i_reg_rd,
   output logic      [7:0]              o_reg_rdata,
   input  wire mcu_irq_pkg::core_req_t  i_core,
   input  wire mcu_irq_pkg::reset_req_t i_reset_req,
   input  wire logic [5:0]              i_pins,
   input  wire logic [7:0]              i_timer_zero_count,
   input  wire logic [7:0]              i_periph_events,
   output mcu_irq_pkg::core_ctl_t       o_ctl,
   output logic      [5:0]              o_pin_digital,
   output logic                         o_asleep
);
   import mcu_irq_pkg::*;

   // Any source that is individually enabled, peripherals behind their group enable
   function automatic logic irq_ready(input logic [7:0] ic, input logic [7:0] pf,
                                      input logic [7:0] pe);
      logic periph;
      periph = ic[`IC_PERIPH_EN] & (|(pf & pe));
      irq_ready = (ic[`IC_TIMER_EN] & ic[`IC_TIMER_FLAG])
                | (ic[`IC_EXT_EN] & ic[`IC_EXT_FLAG])
                | (ic[`IC_CHANGE_EN] & ic[`IC_CHANGE_FLAG])
                | periph;
   endfunction

   logic [7:0]   interrupt_control;
   logic [5:0]   pin_change_select;
   logic [7:0]   peripheral_flags;
   logic [7:0]   peripheral_enables;
   logic [7:0]   pin_config;
   logic [5:0]   analog_select;
   logic [7:0]   status;
   logic [3:0]   power_control_reg;
   q_phase_t     phase;
   power_state_t power_state;
   logic         wake_hold;
   logic [5:0]   sync1;
   logic [5:0]   sync2;
   logic [5:0]   sync3;
   logic [5:0]   pin_level;
   logic [5:0]   dig_prev;
   logic [7:0]   timer_prev;
   logic         ext_hold;
   logic         chg_hold;

   logic [7:0]   next_interrupt_control;
   logic [7:0]   next_peripheral_flags;
   logic [7:0]   next_status;
   logic [3:0]   next_power_control;
   logic [7:0]   next_rdata;
   core_ctl_t    next_ctl;

   // Address decode
   wire wr_ic    = i_reg_wr && (i_reg_addr == `OFF_INTERRUPT_CTL);
   wire wr_sel   = i_reg_wr && (i_reg_addr == `OFF_PIN_CHANGE_SEL);
   wire wr_pf    = i_reg_wr && (i_reg_addr == `OFF_PERIPH_FLAGS);
   wire wr_pe    = i_reg_wr && (i_reg_addr == `OFF_PERIPH_ENABLES);
   wire wr_cfg   = i_reg_wr && (i_reg_addr == `OFF_PIN_CONFIG);
   wire wr_ana   = i_reg_wr && (i_reg_addr == `OFF_ANALOG_SELECT);
   wire wr_st    = i_reg_wr && (i_reg_addr == `OFF_STATUS);
   wire wr_power_control_reg  = i_reg_wr && (i_reg_addr == `OFF_POWER_CONTROL);

   // Resets other than power-on
   wire wdt_reset   = i_core.wdt_timeout && (power_state == RUNNING);
   wire wdt_wake    = i_core.wdt_timeout && (power_state == ASLEEP);
   wire reset_any   = i_reset_req.valid || wdt_reset;

   // Digital view of the pins
   wire [5:0] dig   = pin_level & ~analog_select;
   wire ext_now     = dig[`EXT_PIN_INDEX];
   wire ext_prev    = dig_prev[`EXT_PIN_INDEX];
   wire edge_rise   = ext_now && !ext_prev;
   wire edge_fall   = !ext_now && ext_prev;
   wire ext_edge    = pin_config[`EDGE_SEL_BIT] ? edge_rise : edge_fall;
   // Port access can swallow a change; allowed, and avoids a read-modify race
   wire chg_edge    = (|((dig ^ dig_prev) & pin_change_select))
                      && !i_core.port_access;
   wire commit_ok   = (phase == Q4) || (phase == Q1);
   wire ext_set     = (ext_edge || ext_hold) && commit_ok;
   wire chg_set     = (chg_edge || chg_hold) && commit_ok;
   wire timer_set   = (timer_prev == `TIMER_MAX)
                      && (i_timer_zero_count == `TIMER_ZERO);
   wire [7:0] hw_flags = {5'h00, timer_set, ext_set, chg_set};
   wire [7:0] pf_set   = i_periph_events & `PERIPH_IMPL_MASK;

   // Interrupt decision
   wire gie_clear_now = wr_ic && !i_reg_wdata[`IC_GLOBAL_EN];
   wire any_ready     = irq_ready(interrupt_control, peripheral_flags, peripheral_enables);
   wire take = (phase == Q1) && interrupt_control[`IC_GLOBAL_EN] && any_ready
               && !gie_clear_now && (power_state == RUNNING)
               && !wake_hold && !reset_any;
   wire wake_int = (power_state == ASLEEP) && any_ready;
   wire wake_any = (wake_int || wdt_wake) && !i_reset_req.valid;
   wire [12:0] pc_next = i_core.pc + 13'h0001;

   // Control register: hardware set wins over software clear
   always_comb begin
      next_interrupt_control = (wr_ic ? i_reg_wdata : interrupt_control) | hw_flags;
      if (take) begin
         next_interrupt_control[`IC_GLOBAL_EN] = 1'b0;
      end else if (i_core.return_from_irq) begin
         next_interrupt_control[`IC_GLOBAL_EN] = 1'b1;
      end
      if (reset_any) begin
         next_interrupt_control = `IC_RESET;
      end
   end

   always_comb begin
      next_peripheral_flags = ((wr_pf ? i_reg_wdata : peripheral_flags) | pf_set)
                              & `PERIPH_IMPL_MASK;
      if (reset_any) begin
         next_peripheral_flags = `PERIPH_RESET;
      end
   end

   // Status and power control per reset and wake-up cause
   always_comb begin
      next_status        = status;
      next_power_control = power_control_reg;
      if (wr_st) begin
         next_status = {i_reg_wdata[7:5], status[4:3], i_reg_wdata[2:0]};
      end
      if (wr_power_control_reg) begin
         next_power_control = {2'b00, i_reg_wdata[1:0]};
      end
      if (i_core.sleep_enter && (power_state == RUNNING)) begin
         next_status[`ST_TO_BIT] = 1'b1;
         next_status[`ST_PD_BIT] = 1'b0;
      end
      if (wdt_wake) begin
         next_status[`ST_TO_BIT] = 1'b0;
         next_status[`ST_PD_BIT] = 1'b0;
      end else if (wake_int) begin
         next_status[`ST_TO_BIT] = 1'b1;
         next_status[`ST_PD_BIT] = 1'b0;
      end
      if (wdt_reset) begin
         next_status        = {4'h0, status[3:0]};
         next_power_control = {1'b0, power_control_reg[2:0]};
      end
      if (i_reset_req.valid) begin
         if (i_reset_req.cause == RST_BROWN_OUT) begin
            next_status        = {3'b000, 2'b11, status[2:0]};
            next_power_control = `POWER_CONTROL_REG_BOR;
         end else if (power_state == ASLEEP) begin
            next_status        = {3'b000, 2'b10, status[2:0]};
            next_power_control = {1'b0, power_control_reg[2:0]};
         end else begin
            next_status        = {3'b000, status[4:0]};
            next_power_control = {1'b0, power_control_reg[2:0]};
         end
      end
   end

   // Core control: only the return address is saved
   always_comb begin
      next_ctl = '0;
      if (reset_any) begin
         next_ctl.pc_load = 1'b1;
         next_ctl.pc_addr = `PC_RESET;
      end else if (take) begin
         next_ctl.pc_load   = 1'b1;
         next_ctl.pc_addr   = `PC_VECTOR;
         next_ctl.push      = 1'b1;
         next_ctl.push_addr = i_core.pc;
      end else if (wake_any) begin
         next_ctl.pc_load = 1'b1;
         next_ctl.pc_addr = pc_next;
      end
   end

   // Read mux; unmapped reads as zero
   always_comb begin
      case (i_reg_addr)
         `OFF_INTERRUPT_CTL:  next_rdata = interrupt_control;
         `OFF_PIN_CHANGE_SEL: next_rdata = {2'b00, pin_change_select};
         `OFF_PERIPH_FLAGS:   next_rdata = peripheral_flags;
         `OFF_PERIPH_ENABLES: next_rdata = peripheral_enables;
         `OFF_PIN_CONFIG:     next_rdata = pin_config;
         `OFF_ANALOG_SELECT:  next_rdata = {2'b00, analog_select};
         `OFF_STATUS:         next_rdata = status;
         `OFF_POWER_CONTROL:  next_rdata = {4'h0, power_control_reg};
         default:             next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         interrupt_control <= `IC_RESET;
         peripheral_flags  <= `PERIPH_RESET;
         status            <= `STATUS_POR;
         power_control_reg <= `POWER_CONTROL_REG_POR;
         o_ctl             <= '0;
         o_reg_rdata       <= 8'h00;
      end else begin
         interrupt_control <= next_interrupt_control;
         peripheral_flags  <= next_peripheral_flags;
         status            <= next_status;
         power_control_reg <= next_power_control;
         o_ctl             <= next_ctl;
         o_reg_rdata       <= i_reg_rd ? next_rdata : 8'h00;
      end
   end

   // Plain software registers
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pin_change_select  <= `PIN_SEL_RESET;
         peripheral_enables <= `PERIPH_RESET;
         pin_config         <= `PIN_CFG_RESET;
         analog_select      <= `ANALOG_RESET;
      end else if (reset_any) begin
         pin_change_select  <= `PIN_SEL_RESET;
         peripheral_enables <= `PERIPH_RESET;
      end else begin
         if (wr_sel) pin_change_select <= i_reg_wdata[5:0];
         if (wr_pe) peripheral_enables <= i_reg_wdata & `PERIPH_IMPL_MASK;
         if (wr_cfg) pin_config <= i_reg_wdata;
         if (wr_ana) analog_select <= i_reg_wdata[5:0];
      end
   end

   // Stages reset low, so a pin idling high shows one rising edge after release
   // Three-stage pin sync; level moves only when stages two and three agree
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync1     <= 6'h00;
         sync2     <= 6'h00;
         sync3     <= 6'h00;
         pin_level <= 6'h00;
         dig_prev  <= 6'h00;
      end else begin
         sync1     <= i_pins;
         sync2     <= sync1;
         sync3     <= sync2;
         pin_level <= (sync2 & sync3) | (pin_level & (sync2 ^ sync3));
         dig_prev  <= dig;
      end
   end

   // Edges seen outside Q4/Q1 wait for the next commit window
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ext_hold   <= 1'b0;
         chg_hold   <= 1'b0;
         timer_prev <= 8'h00;
      end else begin
         ext_hold   <= (ext_edge || ext_hold) && !commit_ok;
         chg_hold   <= (chg_edge || chg_hold) && !commit_ok;
         timer_prev <= i_timer_zero_count;
      end
   end

   // Q phase, sleep state and post-wake hold
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         phase       <= Q1;
         power_state <= RUNNING;
         wake_hold   <= 1'b0;
      end else begin
         case (phase)
            Q1:      phase <= Q2;
            Q2:      phase <= Q3;
            Q3:      phase <= Q4;
            Q4:      phase <= Q1;
            default: phase <= Q1;
         endcase
         case (power_state)
            RUNNING: if (i_core.sleep_enter && !reset_any) power_state <= ASLEEP;
            ASLEEP:  if (wake_any || i_reset_req.valid) power_state <= RUNNING;
            default: power_state <= RUNNING;
         endcase
         // PC+1 runs until the first Q4 after the wake cycle before any vector
         if (wake_any) begin
            wake_hold <= 1'b1;
         end else if (phase == Q4) begin
            wake_hold <= 1'b0;
         end
      end
   end

   assign o_pin_digital = dig;
   assign o_asleep      = (power_state == ASLEEP);

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   sequence seq_take;
      take;
   endsequence
   sequence seq_vector_out;
      o_ctl.pc_load && o_ctl.push && (o_ctl.pc_addr == `PC_VECTOR)
      && !interrupt_control[`IC_GLOBAL_EN];
   endsequence

   a_take_needs_gie:
      assert property (o_ctl.push |-> $past(interrupt_control[`IC_GLOBAL_EN])
                       && $past(phase) == Q1)
      else $error("interrupt taken with global enable clear");
   a_take_vectors:
      assert property (seq_take |=> seq_vector_out)
      else $error("take did not vector and clear global enable");
   a_return_sets_gie:
      assert property (i_core.return_from_irq && !take && !reset_any
                       |=> interrupt_control[`IC_GLOBAL_EN])
      else $error("return from interrupt left global enable clear");
   a_reset_clears_ctl:
      assert property (reset_any |=> interrupt_control == `IC_RESET && o_ctl.pc_load
                       && o_ctl.pc_addr == `PC_RESET)
      else $error("reset did not clear control and load pc zero");
   a_ext_flag_set:
      assert property (ext_set && !reset_any |=> interrupt_control[`IC_EXT_FLAG])
      else $error("external edge did not set its flag");
   a_change_flag_set:
      assert property (chg_set && !reset_any |=> interrupt_control[`IC_CHANGE_FLAG])
      else $error("selected pin change did not set its flag");
   a_flag_phase:
      assert property ($rose(interrupt_control[`IC_EXT_FLAG]) && !$past(wr_ic)
                       |-> $past(phase) == Q4 || $past(phase) == Q1)
      else $error("external flag set outside Q4 or Q1");
   a_gie_clear_blocks:
      assert property (gie_clear_now |=> !o_ctl.push)
      else $error("take in the cycle global enable is cleared");
   a_bit4_zero:
      assert property (peripheral_flags[4] == 1'b0 && peripheral_enables[4] == 1'b0)
      else $error("unimplemented peripheral bit set");
   a_wake_next_pc:
      assert property (wake_any && !wdt_reset
                       |=> o_ctl.pc_load && o_ctl.pc_addr == $past(pc_next) && !o_asleep)
      else $error("wake-up did not continue at pc plus one");
   a_timer_wrap:
      assert property (timer_set && !reset_any |=> interrupt_control[`IC_TIMER_FLAG])
      else $error("timer wrap did not set flag");
endmodule

// [verification/core_model.sv]
// Purpose: Behavioural processor core on the far side of the interrupt controller
// Assumes: One program step per clock, enough to follow vectoring and wake-up
// Notes:   Records each load so the bench can judge the target and return address
`timescale 1ns/1ps

module core_model (
   input  wire logic                   i_core_clk,
   input  wire logic                   i_nrst,
   input  wire mcu_irq_pkg::core_ctl_t i_ctl,
   output logic [12:0]                 o_pc,
   output logic [12:0]                 o_prev_pc,
   output int                          o_loads,
   output logic [12:0]                 o_load_addr,
   output logic [12:0]                 o_load_prev,
   output logic [12:0]                 o_stack_top
);
   import mcu_irq_pkg::*;

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pc        <= 13'h0000;
         o_prev_pc   <= 13'h0000;
         o_loads     <= 0;
         o_load_addr <= 13'h0000;
         o_load_prev <= 13'h0000;
         o_stack_top <= 13'h0000;
      end else begin
         o_prev_pc <= o_pc;
         if (i_ctl.pc_load) begin
            o_pc        <= i_ctl.pc_addr;
            o_loads     <= o_loads + 1;
            o_load_addr <= i_ctl.pc_addr;
            o_load_prev <= o_prev_pc;
         end else begin
            o_pc <= o_pc + 13'h0001;
         end
         // Only the return address goes on the stack
         if (i_ctl.push) begin
            o_stack_top <= i_ctl.push_addr;
         end
      end
   end
endmodule

// [verification/tb.sv]
// Purpose: Self-checking bench of the interrupt controller
// Assumes: Register port with one-cycle strobes, core model on the far side
// Notes:   Waits are bounded; a lost answer ends the run
`timescale 1ns/1ps
`include "mcu_irq_cfg.svh"

module tb;
   import mcu_irq_pkg::*;
   logic               clk;
   logic               nrst;
   logic [3:0]         addr;
   logic [7:0]         wdata;
   logic               wr_s;
   logic               rd_s;
   logic [7:0]         rdata;
   logic               ret;
   logic               slp;
   logic               wdt;
   logic               pacc;
   core_req_t          core;
   reset_req_t         rq;
   logic [5:0]         pins;
   logic [7:0]         tmr;
   logic [7:0]         pe;
   core_ctl_t          ctl;
   logic [5:0]         pin_dig;
   logic               asleep;
   logic [12:0]        pc;
   logic [12:0]        load_addr;
   logic [12:0]        load_prev;
   logic [12:0]        stack_top;
   int                 loads;
   int                 err_count;
   int                 cmp_count;
   int                 mark;
   int                 n;

   assign core = '{ret, slp, pacc, wdt, pc};

   mcu_interrupt_controller i_dut (
      .i_core_clk(clk), .i_nrst(nrst), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata), .i_core(core),
      .i_reset_req(rq), .i_pins(pins), .i_timer_zero_count(tmr),
      .i_periph_events(pe), .o_ctl(ctl), .o_pin_digital(pin_dig), .o_asleep(asleep));

   core_model i_core (
      .i_core_clk(clk), .i_nrst(nrst), .i_ctl(ctl), .o_pc(pc), .o_prev_pc(),
      .o_loads(loads), .o_load_addr(load_addr), .o_load_prev(load_prev),
      .o_stack_top(stack_top));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask

   task automatic rdc(input string name, input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      check(name, rdata, exp);
   endtask

   // Settle time covers the pin synchroniser and a full Q cycle
   task automatic pin(input int idx, input logic v);
      @(posedge clk);
      pins[idx] <= v;
      repeat (14) @(posedge clk);
   endtask

   task automatic wait_load();
      n = 0;
      while (loads == mark && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (loads == mark) begin
         err_count++;
         $display("mismatch pc_load expected load seen none");
         end_sim();
      end
   endtask

   task automatic quiet(input string name, input int cyc);
      mark = loads;
      repeat (cyc) @(posedge clk);
      check(name, 16'(loads), 16'(mark));
   endtask

   initial begin
      {addr, wdata, wr_s, rd_s, ret, slp, wdt, pacc, tmr, pe} = '0;
      rq = '{1'b0, RST_EXT_PIN};
      pins = 6'h3f;
      nrst = 1'b0;
      err_count = 0;
      cmp_count = 0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      rdc("ctl_rst", `OFF_INTERRUPT_CTL, 8'h00);
      rdc("pflag_rst", `OFF_PERIPH_FLAGS, 8'h00);
      rdc("pen_rst", `OFF_PERIPH_ENABLES, 8'h00);
      rdc("status_por", `OFF_STATUS, 8'h18);
      rdc("power_por", `OFF_POWER_CONTROL, 8'h04);
      wr(`OFF_PERIPH_ENABLES, 8'hff);
      rdc("pen_bit4", `OFF_PERIPH_ENABLES, 8'hef);
      wr(4'hf, 8'hff);
      rdc("unmapped", 4'hf, 8'h00);
      // Timer wrap with every enable in the control register clear
      mark = loads;
      @(posedge clk) tmr <= `TIMER_MAX;
      @(posedge clk) tmr <= `TIMER_ZERO;
      rdc("timer_flag", `OFF_INTERRUPT_CTL, 8'h04);
      check("no_take", 16'(loads), 16'(mark));
      wr(`OFF_INTERRUPT_CTL, 8'h00);
      pin(2, 1'b0);
      rdc("fall_edge", `OFF_INTERRUPT_CTL, 8'h02);
      wr(`OFF_INTERRUPT_CTL, 8'h00);
      pin(2, 1'b1);
      rdc("rise_ignored", `OFF_INTERRUPT_CTL, 8'h00);
      wr(`OFF_PIN_CONFIG, 8'h01);
      pin(2, 1'b0);
      pin(2, 1'b1);
      rdc("rise_edge", `OFF_INTERRUPT_CTL, 8'h02);
      wr(`OFF_ANALOG_SELECT, 8'h04);
      wr(`OFF_INTERRUPT_CTL, 8'h00);
      check("analog_pin", pin_dig[2], 1'b0);
      pin(2, 1'b0);
      pin(2, 1'b1);
      rdc("analog_quiet", `OFF_INTERRUPT_CTL, 8'h00);
      wr(`OFF_ANALOG_SELECT, 8'h00);
      pin(2, 1'b0);
      // External take, latency counted from the pin edge
      wr(`OFF_INTERRUPT_CTL, 8'h90);
      mark = loads;
      @(posedge clk) pins[2] <= 1'b1;
      wait_load();
      check("latency", 16'(n >= 3 && n <= 16), 16'h0001);
      check("vector", load_addr, `PC_VECTOR);
      check("push", stack_top, load_prev);
      rdc("gie_clr", `OFF_INTERRUPT_CTL, 8'h12);
      wr(`OFF_INTERRUPT_CTL, 8'h10);
      @(posedge clk) ret <= 1'b1;
      @(posedge clk) ret <= 1'b0;
      rdc("gie_ret", `OFF_INTERRUPT_CTL, 8'h90);
      quiet("no_reentry", 30);
      // Peripheral source with group enable
      wr(`OFF_INTERRUPT_CTL, 8'h00);
      wr(`OFF_PERIPH_ENABLES, 8'h01);
      @(posedge clk) pe <= 8'h11;
      @(posedge clk) pe <= 8'h00;
      rdc("pflag", `OFF_PERIPH_FLAGS, 8'h01);
      wr(`OFF_INTERRUPT_CTL, 8'h80);
      quiet("periph_gate", 20);
      mark = loads;
      wr(`OFF_INTERRUPT_CTL, 8'hc0);
      wait_load();
      check("pend_take", load_addr, `PC_VECTOR);
      rdc("gie_clr2", `OFF_INTERRUPT_CTL, 8'h40);
      wr(`OFF_PERIPH_FLAGS, 8'h00);
      // Pin change on a selected and an unselected pin
      wr(`OFF_INTERRUPT_CTL, 8'h08);
      wr(`OFF_PIN_CHANGE_SEL, 8'h01);
      pin(0, 1'b0);
      rdc("change", `OFF_INTERRUPT_CTL, 8'h09);
      wr(`OFF_INTERRUPT_CTL, 8'h08);
      pin(1, 1'b0);
      rdc("unselected", `OFF_INTERRUPT_CTL, 8'h08);
      // Change while the core holds the port: dropped by choice
      @(posedge clk) pacc <= 1'b1;
      pin(0, 1'b1);
      @(posedge clk) pacc <= 1'b0;
      rdc("port_busy", `OFF_INTERRUPT_CTL, 8'h08);
      // Sleep and wake by the external pin, global enable clear
      wr(`OFF_PIN_CONFIG, 8'h00);
      wr(`OFF_INTERRUPT_CTL, 8'h10);
      @(posedge clk) slp <= 1'b1;
      @(posedge clk) slp <= 1'b0;
      @(posedge clk) #1;
      check("asleep", asleep, 1'b1);
      rdc("status_slp", `OFF_STATUS, 8'h10);
      mark = loads;
      @(posedge clk) pins[2] <= 1'b0;
      wait_load();
      check("awake", asleep, 1'b0);
      check("wake_pc", load_addr, load_prev + 13'h0001);
      rdc("status_wake", `OFF_STATUS, 8'h10);
      quiet("no_vector", 20);
      // Sleep with global enable set: PC+1 first, then the vector
      wr(`OFF_INTERRUPT_CTL, 8'h90);
      @(posedge clk) slp <= 1'b1;
      @(posedge clk) slp <= 1'b0;
      pin(2, 1'b1);
      mark = loads;
      @(posedge clk) pins[2] <= 1'b0;
      wait_load();
      check("wake_pc_gie", load_addr, load_prev + 13'h0001);
      mark = loads;
      wait_load();
      check("wake_vector", load_addr, `PC_VECTOR);
      // Brown-out then watchdog reset
      wr(`OFF_INTERRUPT_CTL, 8'h80);
      mark = loads;
      @(posedge clk) rq <= '{1'b1, RST_BROWN_OUT};
      @(posedge clk) rq.valid <= 1'b0;
      wait_load();
      check("bor_pc", load_addr, `PC_RESET);
      rdc("bor_ctl", `OFF_INTERRUPT_CTL, 8'h00);
      rdc("bor_power", `OFF_POWER_CONTROL, 8'h06);
      rdc("bor_status", `OFF_STATUS, 8'h18);
      mark = loads;
      @(posedge clk) wdt <= 1'b1;
      @(posedge clk) wdt <= 1'b0;
      wait_load();
      check("wdt_pc", load_addr, `PC_RESET);
      rdc("wdt_status", `OFF_STATUS, 8'h08);
      rdc("wdt_power", `OFF_POWER_CONTROL, 8'h06);
      end_sim();
   end
endmodule
